// File: addr_filter.sv
`timescale 1ns/1ps
module addr_filter
  import link_pkg::*;
(
  // local settings
  input  wire logic [7:0] unit_address,
  input  wire logic [7:0] group_address,
  // received header
  input  wire hdr_t       rx_hdr,
  output logic            accept
);

  wire open_local  = (group_address == OPEN_GROUP);
  wire open_remote = (rx_hdr.grp == OPEN_GROUP);
  wire grp_match   = (rx_hdr.grp == group_address);
  wire dst_match   = (rx_hdr.dst == unit_address) || (rx_hdr.dst == BROADCAST_ADDR);

  // open group on either side skips all address checks
  assign accept = open_local || open_remote || (grp_match && dst_match);

endmodule : addr_filter

// File: link_pkg.sv
package link_pkg;

  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  BASE_UNIT_ADDR  = 8'h00;
  localparam logic [7:0]  FIRST_OUTSTN    = 8'h01;
  localparam logic [7:0]  MAX_OUTSTN      = 8'hfe;
  localparam logic [7:0]  BROADCAST_ADDR  = 8'hff;
  localparam logic [7:0]  OPEN_GROUP      = 8'h00;
  localparam logic [7:0]  ALARM_DEST      = 8'h00;

  // poll interval is counted in 100 ms ticks; 182 h fits in 23 bits
  localparam int          POLL_MAX_HOURS  = 182;
  localparam int          TICK_MS         = 100;
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          TICK_CYC        = CLK_HZ / 1000 * TICK_MS;
  localparam int          POLL_MAX_TICKS  = POLL_MAX_HOURS * 3600 * 1000 / TICK_MS;
  localparam int          POLL_W          = $clog2(POLL_MAX_TICKS + 1);

  // default break gap in clock cycles, about three chars at 9600 baud
  localparam int          BREAK_CYC_DEF   = 31_250;
  localparam int          PREAMBLE_BYTES  = 4;
  localparam logic [7:0]  PREAMBLE_BYTE   = 8'h55;

  typedef enum logic [1:0] {
    Q_IMMEDIATE,
    Q_END_OF_MSG,
    Q_RATE_DEP
  } tx_queue_policy_t;

  typedef enum logic [1:0] {
    MODE_POLLED,
    MODE_DATA_ONLY
  } op_mode_t;

  typedef struct packed {
    logic [7:0] unit_address;
    logic [7:0] destination_address;
    logic [7:0] group_address;
    logic [POLL_W-1:0] poll_interval;
    logic [7:0] outstation_count;
  } addr_cfg_t;

  typedef struct packed {
    logic [7:0] src;
    logic [7:0] dst;
    logic [7:0] grp;
  } hdr_t;

endpackage : link_pkg

// File: peer_radio_model.sv
`timescale 1ns/1ps
module peer_radio_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // slow far side: transmitter busy, late poll replies
  input  wire logic stall,
  // design side
  input  wire logic air_valid,
  input  wire logic poll_req,
  output logic      radio_tx_ready,
  output logic      radio_ack,
  output logic      poll_done
);
  logic [2:0] wait_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {radio_tx_ready, radio_ack, poll_done} <= 3'h0;
      wait_q <= 3'h0;
    end else begin
      radio_tx_ready <= !stall;
      radio_ack      <= air_valid;
      wait_q         <= poll_req ? (stall ? 3'h6 : 3'h2) : wait_q - {2'h0, wait_q != 3'h0};
      poll_done      <= wait_q == 3'h1;
    end
  end
endmodule : peer_radio_model

// File: radio_link_assertions.sv
`timescale 1ns/1ps
module radio_link_assertions
  import link_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // settings
  input wire op_mode_t   op_mode,
  input wire addr_cfg_t  cfg,
  input wire logic       collected_data_port_select,
  // receive side
  input wire logic       rx_valid,
  input wire hdr_t       rx_hdr,
  input wire logic       rx_to_port_a,
  input wire logic       rx_to_port_b,
  // transmit side
  input wire logic       air_valid,
  input wire logic [7:0] air_data,
  input wire hdr_t       air_hdr,
  input wire logic       air_keyed,
  // polling
  input wire logic       poll_req,
  input wire logic [7:0] poll_target,
  input wire logic       is_base
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // air bytes seen in this keyed sequence, saturating once the preamble is past
  logic [2:0] pre_q;
  logic [2:0] pre_d;
  assign pre_d = !air_keyed ? 3'h0 : pre_q + {2'h0, air_valid && pre_q < 3'h4};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pre_q <= 3'h0;
    else pre_q <= pre_d;
  end

  sequence s_pre;
    air_valid && pre_q < 3'h4;
  endsequence
  sequence s_rx_grp;
    rx_valid && op_mode == MODE_DATA_ONLY && rx_hdr.grp == cfg.group_address;
  endsequence

  property p_role;
    $stable(op_mode) && $stable(cfg.unit_address)
      |-> is_base == (op_mode == MODE_POLLED && cfg.unit_address == BASE_UNIT_ADDR);
  endproperty
  property p_poll_rng;
    poll_req |-> poll_target >= FIRST_OUTSTN && poll_target <= cfg.outstation_count;
  endproperty
  property p_poll_base;
    poll_req |-> is_base;
  endproperty
  property p_pre;
    s_pre |-> air_data == PREAMBLE_BYTE;
  endproperty
  property p_keyed;
    air_valid |-> air_keyed;
  endproperty
  property p_grp_out;
    air_valid |-> air_hdr.grp == cfg.group_address;
  endproperty
  property p_grp_rej;
    rx_valid && cfg.group_address != OPEN_GROUP && rx_hdr.grp != OPEN_GROUP &&
      rx_hdr.grp != cfg.group_address
      |=> !rx_to_port_a && !rx_to_port_b;
  endproperty
  property p_open;
    rx_valid && op_mode == MODE_DATA_ONLY && cfg.group_address == OPEN_GROUP |=> rx_to_port_a;
  endproperty
  property p_bcast;
    s_rx_grp ##0 rx_hdr.dst == BROADCAST_ADDR |=> rx_to_port_a;
  endproperty
  property p_port_b;
    rx_to_port_b |-> is_base && collected_data_port_select;
  endproperty

  a_role: assert property (p_role) else $error("role does not follow address");
  a_poll_rng: assert property (p_poll_rng) else $error("poll target out of range");
  a_poll_base: assert property (p_poll_base) else $error("poll from non-base");
  a_pre: assert property (p_pre) else $error("preamble byte wrong");
  a_keyed: assert property (p_keyed) else $error("air byte while unkeyed");
  a_grp_out: assert property (p_grp_out) else $error("sent group wrong");
  a_grp_rej: assert property (p_grp_rej) else $error("foreign group accepted");
  a_open: assert property (p_open) else $error("open group rejected");
  a_bcast: assert property (p_bcast) else $error("broadcast rejected");
  a_port_b: assert property (p_port_b) else $error("port b used wrongly");
endmodule : radio_link_assertions

bind radio_link_poll_and_queue radio_link_assertions radio_link_assertions_inst (
  .clk(clk), .rst_n(rst_n), .op_mode(op_mode), .cfg(cfg),
  .collected_data_port_select(collected_data_port_select), .rx_valid(rx_valid),
  .rx_hdr(rx_hdr), .rx_to_port_a(rx_to_port_a), .rx_to_port_b(rx_to_port_b),
  .air_valid(air_valid), .air_data(air_data), .air_hdr(air_hdr), .air_keyed(air_keyed),
  .poll_req(poll_req), .poll_target(poll_target), .is_base(is_base)
);

// File: radio_link_poll_and_queue.sv
// What this block does
// - base polls units one through count contiguously
// - base waits poll interval between sequences
// - zero interval means continuous polling
// - poll interval reaches 182 hours
// - outstation raises no missing-poll condition
// - unit address zero makes the base
// - destination setting ignored while base polls
// - outstation alarms go to destination zero
// - data-only mode still filters on unit address or broadcast, no roles
// - destination 255 is broadcast within group
// - nonzero group inserted and must match unless received group is zero
// - group zero accepts everything, sends zero
// - packet mode retries, no alarm on exhaustion
// - immediate policy starts on one byte
// - wait transmitter ready, then preamble first
// - send until empty, new data retriggers
// - end-of-message policy starts on input break
// - rate-dependent policy picks immediate or break
// - flow control sender before overflow
// - outstation count used only at base
`timescale 1ns/1ps
module radio_link_poll_and_queue
  import link_pkg::*;
#(
  parameter int DEPTH     = 16,
  parameter int TICK_CNT  = TICK_CYC,
  parameter int BREAK_CNT = BREAK_CYC_DEF
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // settings
  input  wire op_mode_t          op_mode,
  input  wire addr_cfg_t         cfg,
  input  wire tx_queue_policy_t  tx_queue_policy,
  input  wire logic              collected_data_port_select,
  input  wire logic              packet_over_air_mode,
  input  wire logic [3:0]        packet_retry_count,
  input  wire logic              port_rate_ge_air,
  input  wire logic              flow_ctrl_en,
  input  wire logic [23:0]       break_idle_cycles,
  // customer serial byte stream
  input  wire logic              ser_valid,
  input  wire logic [7:0]        ser_data,
  output logic                   ser_cts,
  // radio transmitter
  input  wire logic              radio_tx_ready,
  input  wire logic              radio_ack,
  input  wire logic              radio_ack_timeout,
  output logic                   air_valid,
  output logic [7:0]             air_data,
  output hdr_t                   air_hdr,
  output logic                   air_keyed,
  // poll requests and alarms
  input  wire logic              poll_done,
  input  wire logic              alarm_req,
  output logic                   poll_req,
  output logic [7:0]             poll_target,
  // radio receive
  input  wire logic              rx_valid,
  input  wire hdr_t              rx_hdr,
  input  wire logic [7:0]        rx_data,
  output logic                   rx_to_port_a,
  output logic                   rx_to_port_b,
  output logic [7:0]             rx_out_data,
  output logic                   is_base,
  output logic                   retry_exhausted
);

  initial begin
    if (DEPTH < 2) $error("DEPTH too small");
    if (TICK_CNT < 1 || BREAK_CNT < 1) $error("counts must be positive");
  end

  // ---------------- role and addressing
  wire polled    = (op_mode == MODE_POLLED);
  wire base_role = polled && (cfg.unit_address == BASE_UNIT_ADDR);
  wire accept;

  addr_filter u_filt (
    .unit_address  (cfg.unit_address),
    .group_address (cfg.group_address),
    .rx_hdr        (rx_hdr),
    .accept        (accept)
  );

  // ---------------- poll sequencer
  typedef enum logic [1:0] {P_IDLE, P_POLL, P_WAIT_RSP, P_GAP} poll_st_t;
  poll_st_t          pst_q, pst_d;
  logic [7:0]        tgt_q, tgt_d;
  logic [31:0]       tick_q;
  logic [POLL_W-1:0] gap_q;
  logic              preq_q;

  wire count_ok  = (cfg.outstation_count != 8'h00) && (cfg.outstation_count <= MAX_OUTSTN);
  wire last_unit = (tgt_q >= cfg.outstation_count);
  wire tick      = (tick_q == 32'(TICK_CNT - 1));
  wire gap_done  = (gap_q >= cfg.poll_interval);

  always_comb begin
    pst_d = pst_q;
    tgt_d = tgt_q;
    case (pst_q)
      P_IDLE:     if (base_role && count_ok) begin
        pst_d = P_POLL;
        tgt_d = FIRST_OUTSTN;
      end
      P_POLL:     pst_d = P_WAIT_RSP;
      P_WAIT_RSP: if (!base_role) pst_d = P_IDLE;
        else if (poll_done) begin
          if (!last_unit) begin
            tgt_d = tgt_q + 8'h01;
            pst_d = P_POLL;
          end else if (cfg.poll_interval == '0) begin
            tgt_d = FIRST_OUTSTN;
            pst_d = P_POLL;
          end else begin
            pst_d = P_GAP;
          end
        end
      P_GAP:      if (!base_role) pst_d = P_IDLE;
        else if (gap_done) begin
          tgt_d = FIRST_OUTSTN;
          pst_d = P_POLL;
        end
      default:    pst_d = P_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pst_q  <= P_IDLE;
      tgt_q  <= FIRST_OUTSTN;
      preq_q <= 1'b0;
    end else begin
      pst_q  <= pst_d;
      tgt_q  <= tgt_d;
      preq_q <= (pst_d == P_POLL);
    end
  end

  // 100 ms tick and gap counter, only live in the gap state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= '0;
      gap_q  <= '0;
    end else if (pst_q != P_GAP) begin
      tick_q <= '0;
      gap_q  <= '0;
    end else begin
      tick_q <= tick ? '0 : tick_q + 32'd1;
      if (tick) gap_q <= gap_q + 1'b1;
    end
  end

  assign poll_req    = preq_q;
  assign poll_target = tgt_q;
  // outstations have no poll supervision at all, so no alarm output exists

  // ---------------- break detector on serial input
  logic [23:0] idle_q;
  logic        brk_q;
  wire [23:0]  brk_lim = (break_idle_cycles != '0) ? break_idle_cycles : 24'(BREAK_CNT);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= '0;
      brk_q  <= 1'b0;
    end else if (ser_valid) begin
      idle_q <= '0;
      brk_q  <= 1'b0;
    end else if (idle_q < brk_lim) begin
      idle_q <= idle_q + 24'd1;
      brk_q  <= (idle_q + 24'd1 == brk_lim);
    end else begin
      brk_q  <= 1'b0;
    end
  end

  // a full buffer with flow control on is itself a break, since the sender stalls
  logic q_in_ready;
  logic q_empty;
  logic q_out_valid;
  logic [7:0] q_out_data;
  logic q_pop;

  wire use_immediate = (tx_queue_policy == Q_IMMEDIATE) ||
                       (tx_queue_policy == Q_RATE_DEP && port_rate_ge_air);
  wire trig_break    = brk_q || (!q_in_ready && flow_ctrl_en);
  wire trig          = !q_empty && (use_immediate || trig_break);

  tx_queue #(.DEPTH(DEPTH)) u_q (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (ser_valid),
    .in_data   (ser_data),
    .in_ready  (q_in_ready),
    .out_valid (q_out_valid),
    .out_data  (q_out_data),
    .out_ready (q_pop),
    .empty     (q_empty)
  );

  // ---------------- transmit sequencer
  typedef enum logic [1:0] {T_IDLE, T_KEY, T_PRE, T_DATA} tx_st_t;
  tx_st_t     tst_q;
  logic [2:0] pre_q;
  logic       cts_q;
  logic       av_q;
  logic [7:0] ad_q;
  logic       key_q;

  wire send_data = (tst_q == T_DATA) && q_out_valid && radio_tx_ready;
  assign q_pop   = send_data;
  wire pre_last  = (pre_q == 3'(PREAMBLE_BYTES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tst_q <= T_IDLE;
      pre_q <= '0;
    end else begin
      case (tst_q)
        T_IDLE: if (trig) tst_q <= T_KEY;
        T_KEY:  if (radio_tx_ready) begin
          tst_q <= T_PRE;
          pre_q <= '0;
        end
        T_PRE:  if (radio_tx_ready) begin
          pre_q <= pre_q + 3'd1;
          if (pre_last) tst_q <= T_DATA;
        end
        T_DATA: if (q_empty) tst_q <= T_IDLE;
        default: tst_q <= T_IDLE;
      endcase
    end
  end

  // outgoing header: polls go to the target, alarms to base, outstation replies to the sender, else configured dest
  hdr_t hdr_d;
  always_comb begin
    hdr_d.src = cfg.unit_address;
    hdr_d.grp = cfg.group_address;
    if (base_role && pst_q != P_IDLE)
      hdr_d.dst = tgt_q;
    else if (polled && !base_role && alarm_req)
      hdr_d.dst = ALARM_DEST;
    else if (polled && !base_role && rx_valid && accept)
      hdr_d.dst = rx_hdr.src;
    else
      hdr_d.dst = cfg.destination_address;
  end

  // ---------------- packet retries
  logic [3:0] try_q;
  logic       exh_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      try_q <= '0;
      exh_q <= 1'b0;
    end else if (!packet_over_air_mode || radio_ack || tst_q == T_IDLE) begin
      try_q <= '0;
      exh_q <= 1'b0;
    end else if (radio_ack_timeout) begin
      if (try_q < packet_retry_count) try_q <= try_q + 4'd1;
      else exh_q <= 1'b1;
    end
  end

  // ---------------- outputs, all registered
  logic       rxa_q;
  logic       rxb_q;
  logic [7:0] rxd_q;
  logic       base_q;
  hdr_t       hdr_q;

  wire rx_ok = rx_valid && accept;
  wire to_b  = base_role && collected_data_port_select;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cts_q  <= 1'b0;
      av_q   <= 1'b0;
      ad_q   <= '0;
      key_q  <= 1'b0;
      rxa_q  <= 1'b0;
      rxb_q  <= 1'b0;
      rxd_q  <= '0;
      base_q <= 1'b0;
      hdr_q  <= '0;
    end else begin
      // without flow control bytes at a full buffer are dropped by the queue
      cts_q  <= flow_ctrl_en ? q_in_ready : 1'b1;
      av_q   <= (tst_q == T_PRE && radio_tx_ready) || send_data;
      ad_q   <= (tst_q == T_PRE) ? PREAMBLE_BYTE : q_out_data;
      key_q  <= (tst_q != T_IDLE);
      rxa_q  <= rx_ok && !to_b;
      rxb_q  <= rx_ok && to_b;
      rxd_q  <= rx_data;
      base_q <= base_role;
      hdr_q  <= hdr_d;
    end
  end

  assign ser_cts         = cts_q;
  assign air_valid       = av_q;
  assign air_data        = ad_q;
  assign air_keyed       = key_q;
  assign air_hdr         = hdr_q;
  assign rx_to_port_a    = rxa_q;
  assign rx_to_port_b    = rxb_q;
  assign rx_out_data     = rxd_q;
  assign is_base         = base_q;
  assign retry_exhausted = exh_q;

endmodule : radio_link_poll_and_queue

// File: tb.sv
`timescale 1ns/1ps
module tb;
  import link_pkg::*;
  localparam int    TICK = 4;
  logic             clk, rst_n, ser_valid, ser_cts, stall, poll_done, poll_req, is_base;
  logic             collected_data_port_select, flow_ctrl_en, port_rate_ge_air;
  logic             radio_tx_ready, radio_ack, air_valid, air_keyed, rx_valid;
  logic             rx_to_port_a, rx_to_port_b;
  logic             alarm_req, packet_over_air_mode, radio_ack_timeout, retry_exhausted;
  logic [7:0]       ser_data, air_data, poll_target, rx_data, rx_out_data;
  logic [23:0]      break_idle_cycles;
  op_mode_t         op_mode;
  addr_cfg_t        cfg;
  tx_queue_policy_t tx_queue_policy;
  hdr_t             air_hdr, rx_hdr;
  logic [7:0]       air_q[$];
  logic [7:0]       poll_t[$];
  int               poll_c[$];
  int               cyc = 0, na = 0, nb = 0, n_fail = 0, tests_run = 0;

  radio_link_poll_and_queue #(.DEPTH(16), .TICK_CNT(TICK), .BREAK_CNT(8))
    radio_link_poll_and_queue_inst (
    .clk(clk), .rst_n(rst_n), .op_mode(op_mode), .cfg(cfg), .tx_queue_policy(tx_queue_policy),
    .collected_data_port_select(collected_data_port_select),
    .packet_over_air_mode(packet_over_air_mode), .packet_retry_count(4'h3),
    .port_rate_ge_air(port_rate_ge_air),
    .flow_ctrl_en(flow_ctrl_en), .break_idle_cycles(break_idle_cycles),
    .ser_valid(ser_valid), .ser_data(ser_data), .ser_cts(ser_cts),
    .radio_tx_ready(radio_tx_ready), .radio_ack(radio_ack),
    .radio_ack_timeout(radio_ack_timeout),
    .air_valid(air_valid), .air_data(air_data), .air_hdr(air_hdr), .air_keyed(air_keyed),
    .poll_done(poll_done), .alarm_req(alarm_req), .poll_req(poll_req),
    .poll_target(poll_target),
    .rx_valid(rx_valid), .rx_hdr(rx_hdr), .rx_data(rx_data), .rx_to_port_a(rx_to_port_a),
    .rx_to_port_b(rx_to_port_b), .rx_out_data(rx_out_data), .is_base(is_base),
    .retry_exhausted(retry_exhausted));
  peer_radio_model peer_radio_model_inst (
    .clk(clk), .rst_n(rst_n), .stall(stall), .air_valid(air_valid), .poll_req(poll_req),
    .radio_tx_ready(radio_tx_ready), .radio_ack(radio_ack), .poll_done(poll_done));

  always #50 clk = ~clk;

  // outputs are collected at the falling edge, well clear of the launching edge
  always @(negedge clk) begin
    cyc++;
    if (air_valid) air_q.push_back(air_data);
    if (poll_req) begin
      poll_t.push_back(poll_target);
      poll_c.push_back(cyc);
    end
    na += int'(rx_to_port_a);
    nb += int'(rx_to_port_b);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // waits for clear-to-send so a full queue is never offered a byte;
  // cts is registered, so one edge passes first for it to see the previous byte
  task automatic send(input logic [7:0] b);
    int k;
    @(posedge clk);
    @(negedge clk);
    for (k = 0; ser_cts !== 1'b1 && k < 5000; k++) @(negedge clk);
    @(posedge clk);
    ser_valid <= 1'b1;
    ser_data  <= b;
    @(posedge clk);
    ser_valid <= 1'b0;
  endtask : send

  task automatic frame(input int n, input logic [7:0] first);
    int k;
    for (k = 0; air_q.size() < n + 4 && k < 5000; k++) @(negedge clk);
    chk(air_q.size(), n + 4);
    for (int i = 0; i < n + 4; i++) chk(air_q.pop_front(), i < 4 ? PREAMBLE_BYTE : first + 8'(i - 4));
    @(posedge clk);
  endtask : frame

  task automatic rx(input logic [7:0] dst, input logic [7:0] grp, input int exp_a);
    int a0;
    a0 = na;
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_hdr   <= '{8'h07, dst, grp};
    rx_data  <= dst;
    @(posedge clk);
    rx_valid <= 1'b0;
    repeat (3) @(posedge clk);
    chk(na - a0, exp_a);
    chk(rx_out_data, dst);
  endtask : rx

  initial begin
    #(100 * 60000);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    {clk, rst_n, ser_valid, stall, rx_valid, collected_data_port_select, port_rate_ge_air} = '0;
    {ser_data, rx_data, rx_hdr, break_idle_cycles} = '0;
    {alarm_req, packet_over_air_mode, radio_ack_timeout} = '0;
    flow_ctrl_en = 1'b1;
    op_mode = MODE_DATA_ONLY;
    tx_queue_policy = Q_IMMEDIATE;
    cfg = '{8'h05, 8'h09, 8'h03, '0, 8'h00};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    chk($bits(cfg.poll_interval) >= 23, 1);
    for (int i = 0; i < 3; i++) send(8'h10 + 8'(i));
    frame(3, 8'h10);
    chk(air_hdr, {8'h05, 8'h09, 8'h03});
    repeat (20) @(posedge clk);
    chk(air_keyed, 1'b0);
    send(8'h20);
    frame(1, 8'h20);
    tx_queue_policy <= Q_END_OF_MSG;
    break_idle_cycles <= 24'd20;
    send(8'h30);
    send(8'h31);
    repeat (12) @(posedge clk);
    chk(air_q.size(), 0);
    frame(2, 8'h30);
    tx_queue_policy <= Q_RATE_DEP;
    for (int r = 1; r >= 0; r--) begin
      port_rate_ge_air <= r[0];
      send(8'h40);
      repeat (8) @(posedge clk);
      chk(air_q.size() > 0, r[0]);
      frame(1, 8'h40);
    end
    tx_queue_policy <= Q_IMMEDIATE;
    stall <= 1'b1;
    fork
      for (int i = 0; i < 18; i++) send(8'h60 + 8'(i));
      begin
        for (int k = 0; ser_cts !== 1'b0 && k < 500; k++) @(negedge clk);
        chk(ser_cts, 1'b0);
        @(posedge clk);
        packet_over_air_mode <= 1'b1;
        for (int t = 0; t < 4; t++) begin
          @(posedge clk);
          radio_ack_timeout <= 1'b1;
          @(posedge clk);
          radio_ack_timeout <= 1'b0;
          @(negedge clk);
          chk(retry_exhausted, t == 3);
        end
        repeat (30) @(posedge clk);
        stall <= 1'b0;
        packet_over_air_mode <= 1'b0;
      end
    join
    frame(18, 8'h60);
    rx(8'h05, 8'h03, 1);
    rx(8'hff, 8'h03, 1);
    rx(8'h05, 8'h04, 0);
    rx(8'h07, 8'h03, 0);
    cfg.group_address <= OPEN_GROUP;
    rx(8'h07, 8'h08, 1);
    send(8'h01);
    frame(1, 8'h01);
    chk(air_hdr.grp, 8'h00);
    cfg <= '{8'h00, 8'h09, 8'h03, POLL_W'(2), 8'h03};
    repeat (20) @(posedge clk);
    chk({is_base, 8'(poll_t.size())}, 9'h000);
    op_mode <= MODE_POLLED;
    collected_data_port_select <= 1'b1;
    for (int k = 0; poll_t.size() < 4 && k < 500; k++) @(posedge clk);
    for (int i = 0; i < 4; i++) chk(poll_t[i], (i % 3) + 1);
    chk(poll_c[3] - poll_c[2] >= poll_c[2] - poll_c[1] + 2 * TICK, 1);
    chk(is_base, 1'b1);
    rx(8'h00, 8'h03, 0);
    chk(nb, 1);
    cfg.poll_interval <= '0;
    repeat (40) @(posedge clk);
    poll_t.delete();
    poll_c.delete();
    for (int k = 0; poll_t.size() < 5 && k < 500; k++) @(posedge clk);
    for (int i = 2; i < 5; i++) chk((poll_c[i] - poll_c[i-1] - poll_c[1] + poll_c[0]) inside {[-1:1]}, 1);
    cfg.unit_address <= 8'h02;
    repeat (10) @(posedge clk);
    poll_t.delete();
    repeat (60) @(posedge clk);
    chk({is_base, 8'(poll_t.size())}, 9'h000);
    alarm_req <= 1'b1;
    repeat (2) @(posedge clk);
    chk(air_hdr.dst, ALARM_DEST);
    tally_and_finish();
  end
endmodule : tb

// File: tx_queue.sv
`timescale 1ns/1ps
module tx_queue
  import link_pkg::*;
#(
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // fill side
  input  wire logic       in_valid,
  input  wire logic [7:0] in_data,
  output logic            in_ready,
  // drain side
  output logic            out_valid,
  output logic [7:0]      out_data,
  input  wire logic       out_ready,
  output logic            empty
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("tx_queue: DEPTH must be power of 2");
  end

  logic [7:0]  mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;

  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire push = in_valid && !full;
  wire pop  = out_valid && out_ready;

  assign in_ready  = !full;
  assign empty     = (wr_q == rd_q);
  assign out_valid = !empty;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end

endmodule : tx_queue
